// File: verilog/asc_params.svh
// Register indices, field positions, reset values and key codes of the scan controller
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH
`define ASC_NUM_AN 16
`define ASC_NUM_SRC 18
`define ASC_TEMP_IDX 5'h10
`define ASC_VREF_IDX 5'h11
`define ASC_REG_GRP_A 8'h00
`define ASC_REG_GRP_B 8'h01
`define ASC_REG_GRP_C 8'h02
`define ASC_REG_ACC_SEL 8'h03
`define ASC_REG_ACC_CNT 8'h04
`define ASC_REG_CTRL_EXT 8'h05
`define ASC_REG_TRIG_SEL 8'h06
`define ASC_REG_GRP_C_TRIG 8'h07
`define ASC_REG_INT_SRC 8'h08
`define ASC_REG_GRP_C_EXT 8'h09
`define ASC_REG_PRIO 8'h0a
`define ASC_REG_WA_SEL 8'h0b
`define ASC_REG_WA_LOW 8'h0c
`define ASC_REG_WA_HIGH 8'h0d
`define ASC_REG_WA_STAT 8'h0e
`define ASC_REG_WB_SEL 8'h0f
`define ASC_REG_WB_LOW 8'h10
`define ASC_REG_WB_HIGH 8'h11
`define ASC_REG_WB_STAT 8'h12
`define ASC_REG_WIN_MON 8'h13
`define ASC_REG_TIME_SET 8'h14
`define ASC_REG_TIME_UNLOCK 8'h15
`define ASC_REG_SCAN_CMD 8'h16
`define ASC_REG_DATA_BASE 8'h20
`define ASC_REG_STIME_BASE 8'h40
`define ASC_UNLOCK_KEY 16'h00a5
`define ASC_STIME_RESET 8'h0c
`define ASC_TIME_RESET 8'h00
`define ASC_CNT_AVG_BIT 7
`define ASC_RES_LSB 1
`define ASC_AUTO_CLR_BIT 5
`define ASC_FMT_BIT 15
`define ASC_TRIG_B_LSB 0
`define ASC_TRIG_A_LSB 8
`define ASC_TEMP_ACC_BIT 0
`define ASC_TEMP_A_BIT 8
`define ASC_VREF_A_BIT 9
`define ASC_TEMP_B_BIT 10
`define ASC_VREF_B_BIT 11
`define ASC_EXT_SEL_LSB 13
`define ASC_EXT_OUT_BIT 15
`define ASC_DIV3_MUL 17'h15556
`endif

// File: verilog/asc_pkg.sv
// Types of the scan configuration controller
package asc_pkg;
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_CONV = 2'b01,
    ASC_STORE = 2'b11,
    ASC_END = 2'b10
  } asc_state_e;
  typedef struct packed {
    asc_state_e state;
    logic [1:0] grp;
    logic [4:0] chan;
    logic [4:0] rep;
    logic [15:0] acc;
    logic conv_start;
    logic conv_abort;
    logic [2:0] scan_end;
    logic [15:0] rdata;
    logic [15:0] grp_a_chan_mask;
    logic [15:0] grp_b_chan_mask;
    logic [15:0] grp_c_chan_select;
    logic [15:0] accumulate_chan_mask;
    logic [7:0] acc_cnt;
    logic [15:0] ctrl_ext;
    logic [15:0] trig_sel;
    logic [5:0] grp_c_trigger_reg;
    logic [15:0] int_src;
    logic [1:0] grp_c_ext;
    logic group_priority_ctrl;
    logic [15:0] wa_sel;
    logic [15:0] win_a_low_level;
    logic [15:0] win_a_high_level;
    logic [15:0] wa_stat;
    logic [4:0] wb_sel;
    logic [15:0] win_b_low_level;
    logic [15:0] win_b_high_level;
    logic wb_stat;
    logic [7:0] conv_time_setting;
    logic unlock;
    logic [17:0][15:0] data;
    logic [17:0][7:0] sample_time_value;
  } asc_st_s;
endpackage

// File: verilog/asc_scan_ctrl.sv
// Scan configuration and sequencing controller for a 12-bit successive-approximation converter
// Summary of operation
// - Group A/B masks select channels per bit
// - Group C has its own channel select
// - Per-channel bit enables repeated-conversion accumulation
// - Count codes give 1,2,3,4,16 conversions
// - Count register bit 7 selects averaging
// - Control bits 2:1 select resolution
// - Enable bit makes data registers auto-clear
// - Trigger fields: B bits 5:0, A 13:8
// - Temperature sensor selectable into group A
// - Bits 10/11 add temp/vref to B
// - Source bit 0 accumulates temperature result
// - Bits 14:13 input select, 15 output
// - Eight-bit sample time per source
// - Window A levels, selects, status flags
// - Window B registers plus combined monitor
// - Time setting writable only after unlock
// - Group C own trigger and extension
// - Priority lets higher group abort lower
// - Resolution 12/10/8, left/right format bit
// - Separate scan-end pulses per group
`timescale 1ns/1ns
`include "asc_params.svh"
module asc_scan_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Scan triggers
  input wire logic [63:0] trig_src,
  // Converter core
  output logic conv_start,
  output logic conv_abort,
  output logic [4:0] conv_chan,
  output logic [7:0] conv_sample_states,
  output logic [1:0] conv_resolution,
  output logic [7:0] conv_time_setting,
  input wire logic conv_done,
  input wire logic [11:0] conv_result,
  // Extended analog path
  output logic [1:0] ext_input_select,
  output logic ext_output_ctrl,
  // Scan status
  output logic scan_end_a,
  output logic scan_end_b,
  output logic scan_end_c,
  output logic scan_busy
);
  asc_pkg::asc_st_s st_r;
  asc_pkg::asc_st_s st_nxt;

  // Number of conversions for a count code; undefined codes behave as one
  function automatic logic [4:0] rep_count(input logic [2:0] code);
    logic [4:0] n;
    n = 5'h01;
    case (code)
      3'h1: n = 5'h02;
      3'h2: n = 5'h03;
      3'h3: n = 5'h04;
      3'h5: n = 5'h10;
      default: n = 5'h01;
    endcase
    return n;
  endfunction

  // Lowest selected source at or above a start index
  function automatic logic [5:0] next_src(input logic [17:0] mask, input logic [4:0] from);
    logic [5:0] r;
    r = 6'h00;
    for (int i = `ASC_NUM_SRC - 1; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= from)) begin
        r = {1'b1, 5'(i)};
      end
    end
    return r;
  endfunction

  // Derived control fields
  logic [17:0] mask_a;
  logic [17:0] mask_b;
  logic [17:0] mask_c;
  logic [17:0] mask_cur;
  logic [17:0] acc_mask;
  logic [3:0] trig_hit;
  logic [3:0] sw_start;
  logic [1:0] res;
  logic [4:0] need;
  logic summing;
  logic avg_en;
  logic [11:0] sample;
  logic [15:0] sum_new;
  logic [32:0] div3_prod;
  logic [15:0] final_val;
  logic [15:0] aligned;
  logic [5:0] first;
  logic [5:0] after;
  logic [1:0] new_grp;
  logic new_trig;
  logic abort_hit;

  // Source masks: 16 analog bits, then temperature, then reference voltage
  // group masks
  assign mask_a = {st_r.int_src[`ASC_VREF_A_BIT], st_r.int_src[`ASC_TEMP_A_BIT],
                   st_r.grp_a_chan_mask};
  assign mask_b = {st_r.int_src[`ASC_VREF_B_BIT], st_r.int_src[`ASC_TEMP_B_BIT],
                   st_r.grp_b_chan_mask};
  assign mask_c = {st_r.grp_c_ext[1], st_r.grp_c_ext[0], st_r.grp_c_chan_select};
  assign mask_cur = (new_grp == 2'h0) ? mask_a : ((new_grp == 2'h1) ? mask_b : mask_c);
  assign acc_mask = {1'b0, st_r.int_src[`ASC_TEMP_ACC_BIT], st_r.accumulate_chan_mask};

  // Start requests per group from selected trigger line or software command
  assign sw_start = (reg_wr && reg_addr == `ASC_REG_SCAN_CMD) ? {1'b0, reg_wdata[2:0]} : 4'h0;
  assign trig_hit[0] = trig_src[st_r.trig_sel[`ASC_TRIG_A_LSB +: 6]] | sw_start[0];
  assign trig_hit[1] = trig_src[st_r.trig_sel[`ASC_TRIG_B_LSB +: 6]] | sw_start[1];
  assign trig_hit[2] = trig_src[st_r.grp_c_trigger_reg] | sw_start[2];
  assign trig_hit[3] = 1'b0;

  // Fixed priority A over B over C when several start together
  always_comb begin
    new_trig = |trig_hit[2:0];
    new_grp = trig_hit[0] ? 2'h0 : (trig_hit[1] ? 2'h1 : 2'h2);
  end
  assign first = next_src(mask_cur, 5'h00);
  assign after = next_src((st_r.grp == 2'h0) ? mask_a : ((st_r.grp == 2'h1) ? mask_b : mask_c),
                          5'(st_r.chan + 5'h01));
  assign abort_hit = st_r.group_priority_ctrl && new_trig && (new_grp < st_r.grp) &&
                     (st_r.state == asc_pkg::ASC_CONV || st_r.state == asc_pkg::ASC_STORE);

  // Repetition and resolution handling of each result
  // resolution field
  assign res = st_r.ctrl_ext[`ASC_RES_LSB +: 2];
  assign sample = (res == 2'h1) ? (conv_result >> 2) :
                  ((res == 2'h2) ? (conv_result >> 4) : conv_result);
  assign summing = acc_mask[st_r.chan];
  assign need = summing ? rep_count(st_r.acc_cnt[2:0]) : 5'h01;
  assign avg_en = st_r.acc_cnt[`ASC_CNT_AVG_BIT];
  assign sum_new = 16'(st_r.acc + {4'h0, sample});
  assign div3_prod = 33'(st_r.acc) * 33'(`ASC_DIV3_MUL);

  // Final value; averaging divides the sum by the conversion count
  always_comb begin
    final_val = st_r.acc;
    if (summing && avg_en) begin
      case (need)
        5'h02: final_val = st_r.acc >> 1;
        5'h03: final_val = 16'(div3_prod >> 18);
        5'h04: final_val = st_r.acc >> 2;
        5'h10: final_val = st_r.acc >> 4;
        default: final_val = st_r.acc;
      endcase
    end
  end

  // Left alignment applies to single-width results only, a raw sum stays right-aligned
  always_comb begin
    aligned = final_val;
    if (st_r.ctrl_ext[`ASC_FMT_BIT] && !(summing && !avg_en)) begin
      case (res)
        2'h1: aligned = final_val << 6;
        2'h2: aligned = final_val << 8;
        default: aligned = final_val << 4;
      endcase
    end
  end

  // Next state of registers and scan sequencer
  always_comb begin
    st_nxt = st_r;
    st_nxt.conv_start = 1'b0;
    st_nxt.conv_abort = 1'b0;
    st_nxt.scan_end = 3'h0;

    // Scan sequencer
    case (st_r.state)
      asc_pkg::ASC_IDLE: begin
        if (new_trig) begin
          st_nxt.grp = new_grp;
          st_nxt.acc = 16'h0000;
          st_nxt.rep = 5'h00;
          if (first[5]) begin
            st_nxt.chan = first[4:0];
            st_nxt.conv_start = 1'b1;
            st_nxt.state = asc_pkg::ASC_CONV;
          end else begin
            st_nxt.state = asc_pkg::ASC_END;
          end
        end
      end
      asc_pkg::ASC_CONV: begin
        if (conv_done) begin
          st_nxt.acc = sum_new;
          st_nxt.rep = 5'(st_r.rep + 5'h01);
          if (5'(st_r.rep + 5'h01) >= need) begin
            st_nxt.state = asc_pkg::ASC_STORE;
          end else begin
            st_nxt.conv_start = 1'b1;
          end
        end
      end
      asc_pkg::ASC_STORE: begin
        st_nxt.acc = 16'h0000;
        st_nxt.rep = 5'h00;
        if (after[5]) begin
          st_nxt.chan = after[4:0];
          st_nxt.conv_start = 1'b1;
          st_nxt.state = asc_pkg::ASC_CONV;
        end else begin
          st_nxt.state = asc_pkg::ASC_END;
        end
      end
      default: begin
        st_nxt.scan_end[st_r.grp] = 1'b1;
        st_nxt.state = asc_pkg::ASC_IDLE;
      end
    endcase

    if (abort_hit) begin
      st_nxt.grp = new_grp;
      st_nxt.acc = 16'h0000;
      st_nxt.rep = 5'h00;
      st_nxt.conv_abort = 1'b1;
      if (first[5]) begin
        st_nxt.chan = first[4:0];
        st_nxt.conv_start = 1'b1;
        st_nxt.state = asc_pkg::ASC_CONV;
      end else begin
        st_nxt.state = asc_pkg::ASC_END;
      end
    end

    // Register writes
    if (reg_wr) begin
      if (reg_addr == `ASC_REG_GRP_A) begin
        st_nxt.grp_a_chan_mask = reg_wdata;
      end else if (reg_addr == `ASC_REG_GRP_B) begin
        st_nxt.grp_b_chan_mask = reg_wdata;
      end else if (reg_addr == `ASC_REG_GRP_C) begin
        st_nxt.grp_c_chan_select = reg_wdata;
      end else if (reg_addr == `ASC_REG_ACC_SEL) begin
        st_nxt.accumulate_chan_mask = reg_wdata;
      end else if (reg_addr == `ASC_REG_ACC_CNT) begin
        st_nxt.acc_cnt = reg_wdata[7:0];
      end else if (reg_addr == `ASC_REG_CTRL_EXT) begin
        st_nxt.ctrl_ext = reg_wdata;
      end else if (reg_addr == `ASC_REG_TRIG_SEL) begin
        st_nxt.trig_sel = reg_wdata;
      end else if (reg_addr == `ASC_REG_GRP_C_TRIG) begin
        st_nxt.grp_c_trigger_reg = reg_wdata[5:0];
      end else if (reg_addr == `ASC_REG_INT_SRC) begin
        st_nxt.int_src = reg_wdata;
      end else if (reg_addr == `ASC_REG_GRP_C_EXT) begin
        st_nxt.grp_c_ext = reg_wdata[1:0];
      end else if (reg_addr == `ASC_REG_PRIO) begin
        st_nxt.group_priority_ctrl = reg_wdata[0];
      end else if (reg_addr == `ASC_REG_WA_SEL) begin
        st_nxt.wa_sel = reg_wdata;
      end else if (reg_addr == `ASC_REG_WA_LOW) begin
        st_nxt.win_a_low_level = reg_wdata;
      end else if (reg_addr == `ASC_REG_WA_HIGH) begin
        st_nxt.win_a_high_level = reg_wdata;
      end else if (reg_addr == `ASC_REG_WA_STAT) begin
        st_nxt.wa_stat = st_r.wa_stat & ~reg_wdata;
      end else if (reg_addr == `ASC_REG_WB_SEL) begin
        st_nxt.wb_sel = reg_wdata[4:0];
      end else if (reg_addr == `ASC_REG_WB_LOW) begin
        st_nxt.win_b_low_level = reg_wdata;
      end else if (reg_addr == `ASC_REG_WB_HIGH) begin
        st_nxt.win_b_high_level = reg_wdata;
      end else if (reg_addr == `ASC_REG_WB_STAT) begin
        st_nxt.wb_stat = st_r.wb_stat & ~reg_wdata[0];
      end else if (reg_addr == `ASC_REG_TIME_UNLOCK) begin
        st_nxt.unlock = (reg_wdata == `ASC_UNLOCK_KEY);
      end else if (reg_addr == `ASC_REG_TIME_SET) begin
        if (st_r.unlock) begin
          st_nxt.conv_time_setting = reg_wdata[7:0];
        end
        st_nxt.unlock = 1'b0;
      end else if (reg_addr >= `ASC_REG_STIME_BASE &&
                   reg_addr < 8'(`ASC_REG_STIME_BASE + `ASC_NUM_SRC)) begin
        st_nxt.sample_time_value[5'(reg_addr - `ASC_REG_STIME_BASE)] = reg_wdata[7:0];
      end
    end

    if (reg_rd && st_r.ctrl_ext[`ASC_AUTO_CLR_BIT] && reg_addr >= `ASC_REG_DATA_BASE &&
        reg_addr < 8'(`ASC_REG_DATA_BASE + `ASC_NUM_SRC)) begin
      st_nxt.data[5'(reg_addr - `ASC_REG_DATA_BASE)] = 16'h0000;
    end

    // Result store and window compare; a new result wins over clear and read
    if (st_r.state == asc_pkg::ASC_STORE && !abort_hit) begin
      st_nxt.data[st_r.chan] = aligned;
      if (st_r.chan < 5'h10 && st_r.wa_sel[st_r.chan[3:0]] &&
          aligned >= st_r.win_a_low_level && aligned <= st_r.win_a_high_level) begin
        st_nxt.wa_stat[st_r.chan[3:0]] = 1'b1;
      end
      if (st_r.chan == st_r.wb_sel &&
          aligned >= st_r.win_b_low_level && aligned <= st_r.win_b_high_level) begin
        st_nxt.wb_stat = 1'b1;
      end
    end

    // Read data, valid in the cycle after the strobe
    st_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      if (reg_addr == `ASC_REG_GRP_A) begin
        st_nxt.rdata = st_r.grp_a_chan_mask;
      end else if (reg_addr == `ASC_REG_GRP_B) begin
        st_nxt.rdata = st_r.grp_b_chan_mask;
      end else if (reg_addr == `ASC_REG_GRP_C) begin
        st_nxt.rdata = st_r.grp_c_chan_select;
      end else if (reg_addr == `ASC_REG_ACC_SEL) begin
        st_nxt.rdata = st_r.accumulate_chan_mask;
      end else if (reg_addr == `ASC_REG_ACC_CNT) begin
        st_nxt.rdata = {8'h00, st_r.acc_cnt};
      end else if (reg_addr == `ASC_REG_CTRL_EXT) begin
        st_nxt.rdata = st_r.ctrl_ext;
      end else if (reg_addr == `ASC_REG_TRIG_SEL) begin
        st_nxt.rdata = st_r.trig_sel;
      end else if (reg_addr == `ASC_REG_GRP_C_TRIG) begin
        st_nxt.rdata = {10'h000, st_r.grp_c_trigger_reg};
      end else if (reg_addr == `ASC_REG_INT_SRC) begin
        st_nxt.rdata = st_r.int_src;
      end else if (reg_addr == `ASC_REG_GRP_C_EXT) begin
        st_nxt.rdata = {14'h0000, st_r.grp_c_ext};
      end else if (reg_addr == `ASC_REG_PRIO) begin
        st_nxt.rdata = {15'h0000, st_r.group_priority_ctrl};
      end else if (reg_addr == `ASC_REG_WA_SEL) begin
        st_nxt.rdata = st_r.wa_sel;
      end else if (reg_addr == `ASC_REG_WA_LOW) begin
        st_nxt.rdata = st_r.win_a_low_level;
      end else if (reg_addr == `ASC_REG_WA_HIGH) begin
        st_nxt.rdata = st_r.win_a_high_level;
      end else if (reg_addr == `ASC_REG_WA_STAT) begin
        st_nxt.rdata = st_r.wa_stat;
      end else if (reg_addr == `ASC_REG_WB_SEL) begin
        st_nxt.rdata = {11'h000, st_r.wb_sel};
      end else if (reg_addr == `ASC_REG_WB_LOW) begin
        st_nxt.rdata = st_r.win_b_low_level;
      end else if (reg_addr == `ASC_REG_WB_HIGH) begin
        st_nxt.rdata = st_r.win_b_high_level;
      end else if (reg_addr == `ASC_REG_WB_STAT) begin
        st_nxt.rdata = {15'h0000, st_r.wb_stat};
      end else if (reg_addr == `ASC_REG_WIN_MON) begin
        st_nxt.rdata = {14'h0000, st_r.wb_stat, |st_r.wa_stat};
      end else if (reg_addr == `ASC_REG_TIME_SET) begin
        st_nxt.rdata = {8'h00, st_r.conv_time_setting};
      end else if (reg_addr == `ASC_REG_SCAN_CMD) begin
        st_nxt.rdata = {11'h000, st_r.grp, st_r.state != asc_pkg::ASC_IDLE, 2'h0};
      end else if (reg_addr >= `ASC_REG_DATA_BASE &&
                   reg_addr < 8'(`ASC_REG_DATA_BASE + `ASC_NUM_SRC)) begin
        st_nxt.rdata = st_r.data[5'(reg_addr - `ASC_REG_DATA_BASE)];
      end else if (reg_addr >= `ASC_REG_STIME_BASE &&
                   reg_addr < 8'(`ASC_REG_STIME_BASE + `ASC_NUM_SRC)) begin
        st_nxt.rdata = {8'h00, st_r.sample_time_value[5'(reg_addr - `ASC_REG_STIME_BASE)]};
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.conv_time_setting <= `ASC_TIME_RESET;
      st_r.sample_time_value <= {`ASC_NUM_SRC{`ASC_STIME_RESET}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign reg_rdata = st_r.rdata;
  assign conv_start = st_r.conv_start;
  assign conv_abort = st_r.conv_abort;
  assign conv_chan = st_r.chan;
  assign conv_sample_states = st_r.sample_time_value[st_r.chan];
  assign conv_resolution = res;
  assign conv_time_setting = st_r.conv_time_setting;
  assign ext_input_select = st_r.int_src[`ASC_EXT_SEL_LSB +: 2];
  assign ext_output_ctrl = st_r.int_src[`ASC_EXT_OUT_BIT];
  assign scan_end_a = st_r.scan_end[0];
  assign scan_end_b = st_r.scan_end[1];
  assign scan_end_c = st_r.scan_end[2];
  assign scan_busy = (st_r.state != asc_pkg::ASC_IDLE);
endmodule

// File: bench/asc_assertions.sv
// Port-level checker for the scan configuration controller
`timescale 1ns/1ns
`include "asc_params.svh"
module asc_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  // Converter core side
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic conv_done,
  input wire logic [1:0] conv_resolution,
  input wire logic [7:0] conv_time_setting,
  // Extended path and status
  input wire logic [1:0] ext_input_select,
  input wire logic ext_output_ctrl,
  input wire logic scan_end_a,
  input wire logic scan_end_b,
  input wire logic scan_end_c,
  input wire logic scan_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic ulk_r;
  logic [15:0] wd_r;
  logic any_end;
  // Shadow of the unlock state and the last written word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ulk_r <= 1'b0;
    end else if (reg_wr && reg_addr == `ASC_REG_TIME_UNLOCK) begin
      ulk_r <= reg_wdata == `ASC_UNLOCK_KEY;
    end else if (reg_wr && reg_addr == `ASC_REG_TIME_SET) begin
      ulk_r <= 1'b0;
    end
    if (reg_wr) begin
      wd_r <= reg_wdata;
    end
  end
  // Any group finished
  assign any_end = scan_end_a || scan_end_b || scan_end_c;
  property p_res;
    reg_wr && reg_addr == `ASC_REG_CTRL_EXT |=> conv_resolution == $past(reg_wdata[2:1]);
  endproperty
  a_res: assert property (p_res) else $error("resolution differs from write");
  property p_ext;
    reg_wr && reg_addr == `ASC_REG_INT_SRC |-> ##[1:2]
      {ext_output_ctrl, ext_input_select} == wd_r[15:13];
  endproperty
  a_ext: assert property (p_ext) else $error("extended path differs from write");
  property p_lock;
    reg_wr && reg_addr == `ASC_REG_TIME_SET && !ulk_r |=> $stable(conv_time_setting) [*2];
  endproperty
  a_lock: assert property (p_lock) else $error("locked time setting changed");
  property p_open;
    reg_wr && reg_addr == `ASC_REG_TIME_SET && ulk_r |-> ##[1:2] conv_time_setting == wd_r[7:0];
  endproperty
  a_open: assert property (p_open) else $error("unlocked time setting not taken");
  property p_pulse;
    any_end |=> !any_end;
  endproperty
  a_pulse: assert property (p_pulse) else $error("scan end longer than one cycle");
  // one group ends at a time
  property p_excl;
    $onehot0({scan_end_a, scan_end_b, scan_end_c});
  endproperty
  a_excl: assert property (p_excl) else $error("two scan ends at once");
  property p_step;
    conv_done && scan_busy |-> ##[1:3] (conv_start || any_end);
  endproperty
  a_step: assert property (p_step) else $error("no step after a result");
  property p_busy;
    conv_start |-> scan_busy;
  endproperty
  a_busy: assert property (p_busy) else $error("start outside a scan");
  property p_abort;
    conv_abort |-> ##[0:2] conv_start;
  endproperty
  a_abort: assert property (p_abort) else $error("abort without restart");
endmodule
bind asc_scan_ctrl asc_chk u_chk (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .conv_start, .conv_abort, .conv_done, .conv_resolution, .conv_time_setting,
  .ext_input_select, .ext_output_ctrl, .scan_end_a, .scan_end_b, .scan_end_c, .scan_busy);

// File: bench/asc_core_model.sv
// Behavioural converter core answering the sequencer
`timescale 1ns/1ns
module asc_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Requests from the sequencer, and the bench speed select
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic [4:0] conv_chan,
  input wire logic [7:0] conv_sample_states,
  input wire logic slow,
  // Answer to the sequencer
  output logic conv_done,
  output logic [11:0] conv_result
);
  logic [5:0] cnt_r;
  logic [4:0] chan_r;
  logic [7:0] last_stime;
  // One answer per start unless a new start or an abort comes first; result is fixed per source, noise otherwise
  always_ff @(posedge core_clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (!rst_b) begin
      cnt_r <= 6'h00;
      conv_result <= 12'h000;
    end else if (conv_start) begin
      cnt_r <= slow ? 6'h14 : 6'h02;
      chan_r <= conv_chan;
      last_stime <= conv_sample_states;
    end else if (conv_abort) begin
      cnt_r <= 6'h00;
    end else if (cnt_r == 6'h01) begin
      conv_done <= 1'b1;
      conv_result <= 12'h100 + {7'h00, chan_r};
      cnt_r <= 6'h00;
    end else if (cnt_r != 6'h00) begin
      cnt_r <= cnt_r - 6'h01;
    end
  end
endmodule

// File: bench/testbench.sv
// Self-checking bench for the scan configuration controller
`timescale 1ns/1ns
`include "asc_params.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", nm, e, s); end end
module testbench;
  logic core_clk, rst_b, reg_wr, reg_rd, conv_start, conv_abort, conv_done, slow;
  logic [7:0] reg_addr, conv_sample_states, conv_time_setting;
  logic [15:0] reg_wdata, reg_rdata, ev;
  logic [63:0] trig_src;
  logic [4:0] conv_chan;
  logic [1:0] conv_resolution, ext_input_select;
  logic [11:0] conv_result;
  logic ext_output_ctrl, scan_end_a, scan_end_b, scan_end_c, scan_busy;
  int n_fail, tests_run, cyc, n_a, n_b, n_c;
  int cnt_n[5] = '{1, 2, 3, 4, 16};
  logic [2:0] cnt_code[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};
  logic [7:0] ra[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
    8'h41, 8'h0c, 8'h0f};
  logic [15:0] rv[12] = '{16'h00a5, 16'h005a, 16'h00c3, 16'h0081, 16'h0085, 16'h8024,
    16'h2a15, 16'h003f, 16'hef01, 16'h00ff, 16'h0123, 16'h0011};
  asc_scan_ctrl dut (.core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .trig_src, .conv_start, .conv_abort, .conv_chan, .conv_sample_states, .conv_resolution,
    .conv_time_setting, .conv_done, .conv_result, .ext_input_select, .ext_output_ctrl,
    .scan_end_a, .scan_end_b, .scan_end_c, .scan_busy);
  asc_core_model core (.core_clk, .rst_b, .conv_start, .conv_abort, .conv_chan,
    .conv_sample_states, .slow, .conv_done, .conv_result);
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Scan-end tallies off the active edge, and the hang guard
  always @(negedge core_clk) begin
    cyc++;
    n_a += int'(scan_end_a === 1'b1);
    n_b += int'(scan_end_b === 1'b1);
    n_c += int'(scan_end_c === 1'b1);
    if (cyc == 40000) begin
      n_fail++;
      results();
    end
  end
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK($sformatf("reg %h", a), e, reg_rdata)
  endtask
  task wait_idle;
    repeat (3) @(posedge core_clk);
    #1;
    for (int i = 0; i < 2000 && scan_busy !== 1'b0; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (scan_busy !== 1'b0) n_fail++;
  endtask
  task go(input logic [2:0] cmd);
    wr(`ASC_REG_SCAN_CMD, {13'h0, cmd});
    wait_idle();
  endtask
  task pulse(input int ln);
    @(posedge core_clk);
    trig_src <= 64'h1 << ln;
    @(posedge core_clk);
    trig_src <= 64'h0;
    wait_idle();
  endtask
  // Main sequence
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0;
    trig_src = 64'h0;
    slow = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(8'h40, {8'h0, `ASC_STIME_RESET});
    rd(`ASC_REG_TIME_SET, 16'h0);
    for (int i = 0; i < 12; i++) begin
      wr(ra[i], rv[i]);
      rd(ra[i], rv[i]);
    end
    `CHK("resolution", 2'b10, conv_resolution)
    `CHK("ext path", 3'b111, {ext_output_ctrl, ext_input_select})
    wr(8'h17, 16'hffff);
    rd(8'h17, 16'h0);
    // Time setting stays locked until the key is written
    wr(`ASC_REG_TIME_SET, 16'h0033);
    rd(`ASC_REG_TIME_SET, 16'h0);
    wr(`ASC_REG_TIME_UNLOCK, `ASC_UNLOCK_KEY);
    wr(`ASC_REG_TIME_SET, 16'h0033);
    wr(`ASC_REG_TIME_SET, 16'h0044);
    rd(`ASC_REG_TIME_SET, 16'h0033);
    `CHK("time port", 8'h33, conv_time_setting)
    foreach (ra[i]) if (i < 9) wr(ra[i], 16'h0);
    // Triggered group A scan over channels 0 and 2
    wr(8'h00, 16'h0005);
    wr(8'h06, 16'h0500);
    wr(8'h42, 16'h0020);
    pulse(5);
    rd(8'h20, 16'h0100);
    rd(8'h21, 16'h0000);
    rd(8'h22, 16'h0102);
    `CHK("sample states", 8'h20, core.last_stime)
    `CHK("ends a", 1, n_a)
    // Every defined count code, summed then averaged
    wr(8'h00, 16'h0002);
    wr(8'h03, 16'h0002);
    for (int i = 0; i < 10; i++) begin
      wr(8'h04, {8'h0, i > 4, 4'h0, cnt_code[i % 5]});
      go(3'b001);
      ev = (i > 4) ? 16'h0101 : 16'(cnt_n[i % 5] * 257);
      rd(8'h21, ev);
    end
    // Temperature into A with summing, reference into B
    wr(8'h00, 16'h0000);
    wr(8'h04, 16'h0001);
    wr(8'h08, 16'h0101);
    go(3'b001);
    rd(8'h30, 16'h0220);
    wr(8'h08, 16'h0800);
    go(3'b010);
    rd(8'h31, 16'h0111);
    // Group C on its own trigger line
    wr(8'h02, 16'h0008);
    wr(8'h07, 16'h0009);
    pulse(9);
    rd(8'h23, 16'h0103);
    `CHK("ends c", 1, n_c)
    // Auto clear after a read
    wr(8'h05, 16'h0020);
    rd(8'h23, 16'h0103);
    rd(8'h23, 16'h0000);
    wr(8'h05, 16'h0000);
    // Window A on channel 3, window B on the reference source
    wr(8'h0b, 16'h0008);
    wr(8'h0c, 16'h0100);
    wr(8'h0d, 16'h01ff);
    wr(8'h11, 16'h0200);
    pulse(9);
    go(3'b010);
    rd(8'h0e, 16'h0008);
    rd(8'h12, 16'h0001);
    wr(8'h0e, 16'h0008);
    rd(8'h13, 16'h0002);
    // Eight-bit resolution, left aligned
    wr(8'h05, 16'h8004);
    pulse(9);
    rd(8'h23, 16'h1000);
    wr(8'h05, 16'h0000);
    // Group A preempts B with priority, is refused without it
    wr(8'h0a, 16'h0001);
    wr(8'h01, 16'h00ff);
    wr(8'h00, 16'h0001);
    slow <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      wr(`ASC_REG_SCAN_CMD, 16'h0002);
      repeat (8) @(posedge core_clk);
      wr(`ASC_REG_SCAN_CMD, 16'h0001);
      wait_idle();
      wr(8'h0a, 16'h0000);
    end
    `CHK("ends a", 13, n_a)
    `CHK("ends b", 3, n_b)
    results();
  end
endmodule
